// file: rtl/sssr_top.sv
/*
 * Status summary and service request logic: four register groups summed
 * into the status byte, the status byte mask, the master summary and the
 * service request line, serial poll and a command/response port.
 * Assumes a command decoder presents one command per cycle in program
 * order and that the output buffer reports its occupancy as a level.
 */
`timescale 1ns/1ps
//
// Overview of operation
// - condition bits track live state, reads harmless
// - event bit latches once, repeats ignored
// - event bit holds until read or clear
// - clear-status clears events, keeps masks
// - preset clears group masks; masks writable
// - group summary is OR of masked events
// - message-available rises as buffer holds data
// - message-available drops when buffer fully read
// - group event read clears only its summary
// - fixed status byte bit map, bits 0,2 zero
// - master summary is OR of enabled bits
// - mask clears on zero write, power-on per setting
// - request bit rising asserts service request line
// - serial poll clears request bit, releases line
// - serial poll answered next cycle, out of order
// - byte query matches poll, ordered, keeps request
// - byte query never clears request or line
// - completion bit set after prior work and scan
// - queries return binary-weighted register value
module sssr_top
    import sssr_pkg::*;
#(
    parameter int GWIDTH = SSSR_GWIDTH
) (
    input  wire logic                             sys_clk,
    input  wire logic                             rst,
    input  wire logic                             powerOn,
    input  wire logic                             powerOnClear,
    input  wire logic [SSSR_NGRP*GWIDTH-1:0]      condIn,
    input  wire logic                             outBufNotEmpty,
    input  wire logic                             opcCmd,
    input  wire logic                             busyPrior,
    input  wire logic                             scanRunning,
    input  wire sssr_req_t                        req,
    input  wire logic                             serialPoll,
    input  wire logic                             stbQuery,
    output sssr_rsp_t                             rsp,
    output logic      [7:0]                       pollByte,
    output logic                                  pollValid,
    output logic      [7:0]                       summaryStatusByte,
    output logic      [7:0]                       summaryStatusMask,
    output logic                                  srqOut,
    output logic                                  srqOe
);

    logic [SSSR_NGRP*GWIDTH-1:0] condView;
    logic [SSSR_NGRP*GWIDTH-1:0] evtView;
    logic [SSSR_NGRP*GWIDTH-1:0] enaView;
    logic [SSSR_NGRP*GWIDTH-1:0] condFed;
    logic [SSSR_NGRP-1:0]        grpSummary;
    logic [SSSR_NGRP-1:0]        evtClr;
    logic [SSSR_NGRP-1:0]        enaWr;
    logic                        isCls;
    logic                        isPreset;

    logic [7:0]  mask_q;
    logic [7:0]  mask_d;
    logic        rqs_q;
    logic        rqs_d;
    logic        mssPrev_q;
    logic        mssPrev_d;
    logic        opcPend_q;
    logic        opcPend_d;
    logic        opcPulse;
    sssr_rsp_t   rsp_q;
    sssr_rsp_t   rsp_d;
    logic [7:0]  poll_q;
    logic [7:0]  poll_d;
    logic        pollV_q;
    logic        pollV_d;
    logic [7:0]  sbyte;
    logic        mss;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [GWIDTH-1:0] grpSlice(
        input logic [SSSR_NGRP*GWIDTH-1:0] v,
        input logic [1:0]                  g
    );
        grpSlice = v[g*GWIDTH +: GWIDTH];
    endfunction

    function automatic logic cmdHit(
        input sssr_req_t r,
        input sssr_cmd_t c
    );
        cmdHit = r.valid && (r.cmd == c);
    endfunction

    // ------------------------------------------------------------------
    // register groups
    // ------------------------------------------------------------------
    assign isCls    = cmdHit(req, SSSR_CMD_CLS);
    assign isPreset = cmdHit(req, SSSR_CMD_PRESET);

    // completion event injected as a one-cycle pulse into the standard group
    always_comb begin
        condFed = condIn;
        condFed[SSSR_G_STDEV*GWIDTH + SSSR_STDEV_OPC_BIT] = opcPulse;
    end

    // kept out of the next-state process so the read path forms no false loop
    assign opcPulse = opcPend_q && !busyPrior && !scanRunning;

    genvar gi;
    generate
        for (gi = 0; gi < SSSR_NGRP; gi++) begin : g_grp
            // a group event read clears that group only, hence its summary only
            assign evtClr[gi] = isCls
                || (cmdHit(req, SSSR_CMD_EVT_RD) && req.grp == 2'(gi));
            assign enaWr[gi]  = cmdHit(req, SSSR_CMD_ENA_WR) && req.grp == 2'(gi);
            sssr_group #(
                .WIDTH(GWIDTH)
            ) u_grp (
                .sys_clk   (sys_clk),
                .rst       (rst),
                .condIn    (condFed[gi*GWIDTH +: GWIDTH]),
                .evtClear  (evtClr[gi]),
                .enaClear  (isPreset),
                .enaWrite  (enaWr[gi]),
                .enaData   (req.data[GWIDTH-1:0]),
                .condOut   (condView[gi*GWIDTH +: GWIDTH]),
                .eventOut  (evtView[gi*GWIDTH +: GWIDTH]),
                .enableOut (enaView[gi*GWIDTH +: GWIDTH]),
                .summary   (grpSummary[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // status byte and master summary
    // ------------------------------------------------------------------
    always_comb begin
        sbyte                 = 8'h00;
        sbyte[SSSR_BIT_ALARM] = grpSummary[SSSR_G_ALARM];
        sbyte[SSSR_BIT_QUES]  = grpSummary[SSSR_G_QUES];
        sbyte[SSSR_BIT_MAV]   = outBufNotEmpty;
        sbyte[SSSR_BIT_STDEV] = grpSummary[SSSR_G_STDEV];
        sbyte[SSSR_BIT_OPER]  = grpSummary[SSSR_G_OPER];
        // the mask bit for position 6 is ignored, it is the summary itself
        mss = |(sbyte & mask_q & ~SSSR_UNUSED_MASK);
        sbyte[SSSR_BIT_RQS]   = rqs_q;
    end

    // ------------------------------------------------------------------
    // mask, request bit, completion, responses
    // ------------------------------------------------------------------
    always_comb begin
        mask_d    = mask_q;
        rqs_d     = rqs_q;
        mssPrev_d = mss;
        opcPend_d = opcPend_q;
        rsp_d     = '0;
        poll_d    = poll_q;
        pollV_d   = 1'b0;

        if (powerOn && powerOnClear) begin
            mask_d = SSSR_MASK_RESET;
        end else if (cmdHit(req, SSSR_CMD_SRE_WR)) begin
            mask_d = req.data[7:0];
        end

        // request raised on a rising master summary
        if (mss && !mssPrev_q) begin
            rqs_d = 1'b1;
        end else if (serialPoll) begin
            rqs_d = 1'b0;
        end else if (isCls) begin
            rqs_d = 1'b0;
        end else if (!mss) begin
            rqs_d = 1'b0;
        end

        // poll answers the cycle after its input, ahead of queued commands
        if (serialPoll) begin
            poll_d  = sbyte;
            pollV_d = 1'b1;
        end

        if (opcCmd) begin
            opcPend_d = 1'b1;
        end
        if (opcPulse) begin
            opcPend_d = opcCmd;
        end

        // query answers carry the raw binary-weighted value
        if (stbQuery) begin
            rsp_d.valid = 1'b1;
            rsp_d.data  = {8'h00, sbyte};
        end else if (req.valid) begin
            case (req.cmd)
                SSSR_CMD_EVT_RD: begin
                    rsp_d.valid = 1'b1;
                    rsp_d.data  = grpSlice(evtView, req.grp);
                end
                SSSR_CMD_COND_RD: begin
                    rsp_d.valid = 1'b1;
                    rsp_d.data  = grpSlice(condView, req.grp);
                end
                SSSR_CMD_ENA_RD: begin
                    rsp_d.valid = 1'b1;
                    rsp_d.data  = (req.grp == 2'(SSSR_NGRP - 1) && req.data[0])
                                  ? {8'h00, mask_q} : grpSlice(enaView, req.grp);
                end
                default: begin
                    rsp_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mask_q    <= SSSR_MASK_RESET;
            rqs_q     <= 1'b0;
            mssPrev_q <= 1'b0;
            opcPend_q <= 1'b0;
            rsp_q     <= '0;
            poll_q    <= 8'h00;
            pollV_q   <= 1'b0;
        end else begin
            mask_q    <= mask_d;
            rqs_q     <= rqs_d;
            mssPrev_q <= mssPrev_d;
            opcPend_q <= opcPend_d;
            rsp_q     <= rsp_d;
            poll_q    <= poll_d;
            pollV_q   <= pollV_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rsp               = rsp_q;
    assign pollByte          = poll_q;
    assign pollValid         = pollV_q;
    assign summaryStatusByte = sbyte;
    assign summaryStatusMask = mask_q;
    // open drain, active low on the wire: pull low while requesting
    assign srqOut            = 1'b0;
    assign srqOe             = rqs_q;

endmodule

// file: rtl/sssr_pkg.sv
/*
 * Package for the status summary / service request block: status byte bit
 * positions, group widths, reset values and the command port carrier.
 * Assumes one synchronous clock domain; no other package is needed.
 */
package sssr_pkg;

    // ------------------------------------------------------------------
    // status byte layout
    // ------------------------------------------------------------------
    localparam int SSSR_BIT_ALARM = 1;
    localparam int SSSR_BIT_QUES  = 3;
    localparam int SSSR_BIT_MAV   = 4;
    localparam int SSSR_BIT_STDEV = 5;
    localparam int SSSR_BIT_RQS   = 6;
    localparam int SSSR_BIT_OPER  = 7;
    localparam logic [7:0] SSSR_UNUSED_MASK = 8'h05;

    // ------------------------------------------------------------------
    // group indices and widths
    // ------------------------------------------------------------------
    localparam int SSSR_NGRP   = 4;
    localparam int SSSR_GWIDTH = 16;
    localparam int SSSR_G_ALARM = 0;
    localparam int SSSR_G_QUES  = 1;
    localparam int SSSR_G_STDEV = 2;
    localparam int SSSR_G_OPER  = 3;
    localparam int SSSR_STDEV_OPC_BIT = 0;

    localparam logic [7:0]  SSSR_MASK_RESET  = 8'h00;
    localparam logic [15:0] SSSR_GRP_RESET   = 16'h0000;

    // ------------------------------------------------------------------
    // command port carrier
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SSSR_CMD_NONE,
        SSSR_CMD_CLS,
        SSSR_CMD_PRESET,
        SSSR_CMD_SRE_WR,
        SSSR_CMD_ENA_WR,
        SSSR_CMD_EVT_RD,
        SSSR_CMD_COND_RD,
        SSSR_CMD_ENA_RD
    } sssr_cmd_t;

    typedef struct packed {
        logic       valid;
        sssr_cmd_t  cmd;
        logic [1:0] grp;
        logic [15:0] data;
    } sssr_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } sssr_rsp_t;

endpackage

// file: rtl/sssr_group.sv
/*
 * One status register group: condition, latching event and enable.
 * Assumes commands arrive in order and are pulses one cycle long.
 */
`timescale 1ns/1ps
module sssr_group
    import sssr_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] condIn,
    input  wire logic             evtClear,
    input  wire logic             enaClear,
    input  wire logic             enaWrite,
    input  wire logic [WIDTH-1:0] enaData,
    output logic      [WIDTH-1:0] condOut,
    output logic      [WIDTH-1:0] eventOut,
    output logic      [WIDTH-1:0] enableOut,
    output logic                  summary
);

    logic [WIDTH-1:0] condPrev_q;
    logic [WIDTH-1:0] condPrev_d;
    logic [WIDTH-1:0] event_q;
    logic [WIDTH-1:0] event_d;
    logic [WIDTH-1:0] enable_q;
    logic [WIDTH-1:0] enable_d;
    logic [WIDTH-1:0] rise;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        condPrev_d = condIn;
        rise       = condIn & ~condPrev_q;
        // set beats clear; a set bit simply stays, repeats are not counted
        event_d    = (evtClear ? '0 : event_q) | rise;
        enable_d   = enable_q;
        if (enaClear) begin
            enable_d = '0;
        end else if (enaWrite) begin
            enable_d = enaData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            condPrev_q <= '0;
            event_q    <= '0;
            enable_q   <= '0;
        end else begin
            condPrev_q <= condPrev_d;
            event_q    <= event_d;
            enable_q   <= enable_d;
        end
    end

    assign condOut   = condIn;
    assign eventOut  = event_q;
    assign enableOut = enable_q;
    assign summary   = |(event_q & enable_q);

endmodule

// file: tb/sssr_top_monitor.sv
/* Checker for the status summary block, watching its top ports only.
   Assumes one clock domain with a synchronous active-high reset. */
`timescale 1ns/1ps
module sssr_top_monitor
    import sssr_pkg::*;
#(
    parameter int GWIDTH = SSSR_GWIDTH
) (
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       powerOn,
    input wire logic       powerOnClear,
    input wire logic       outBufNotEmpty,
    input wire logic       serialPoll,
    input wire logic       stbQuery,
    input wire logic       pollValid,
    input wire logic       srqOut,
    input wire logic       srqOe,
    input wire sssr_req_t  req,
    input wire sssr_rsp_t  rsp,
    input wire logic [7:0] pollByte,
    input wire logic [7:0] summaryStatusByte,
    input wire logic [7:0] summaryStatusMask
);
    logic       mss;
    logic       rdReq;
    logic [7:0] sreData;
    // master summary rebuilt from ports; request bit and unused bits left out
    assign mss     = |(summaryStatusByte & summaryStatusMask & 8'hBA);
    assign rdReq   = req.valid && !stbQuery && req.cmd inside {SSSR_CMD_EVT_RD,
                     SSSR_CMD_COND_RD, SSSR_CMD_ENA_RD};
    assign sreData = req.data[7:0];
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_mav_live: assert property (
        summaryStatusByte[SSSR_BIT_MAV] == outBufNotEmpty) else $error("mav wrong");
    a_unused_zero: assert property (
        (summaryStatusByte & SSSR_UNUSED_MASK) == 8'h00) else $error("unused bit set");
    a_read_answer: assert property (
        rdReq |=> rsp.valid) else $error("read not answered");
    a_mask_write: assert property (
        req.valid && req.cmd == SSSR_CMD_SRE_WR && !powerOn |=>
        summaryStatusMask == $past(sreData) && !rsp.valid) else $error("mask write");
    a_mask_power: assert property (
        powerOn && powerOnClear && !req.valid |=> summaryStatusMask == 8'h00)
        else $error("mask kept at power-on");
    a_poll_byte: assert property (
        serialPoll |=> pollValid && pollByte == $past(summaryStatusByte))
        else $error("poll byte wrong");
    a_poll_release: assert property (
        serialPoll && mss && $past(mss) |=> !srqOe) else $error("poll kept request");
    a_srq_line: assert property (
        srqOe == summaryStatusByte[SSSR_BIT_RQS] && !srqOut) else $error("srq line");
    a_rqs_rise: assert property (
        $rose(mss) && !serialPoll |=> srqOe) else $error("request not raised");
    a_query_keep: assert property (
        stbQuery && srqOe && mss && !serialPoll && !(req.valid && req.cmd == SSSR_CMD_CLS)
            ##1 mss |-> srqOe)
        else $error("query dropped request");
    a_cls_request: assert property (
        req.valid && req.cmd == SSSR_CMD_CLS && !$rose(mss) |=> !srqOe)
        else $error("clear status kept request");
    a_query_data: assert property (
        stbQuery |=> rsp.valid && rsp.data == {8'h00, $past(summaryStatusByte)})
        else $error("query data wrong");
endmodule
bind sssr_top sssr_top_monitor #(.GWIDTH(GWIDTH)) mon (
    .sys_clk, .rst, .powerOn, .powerOnClear, .outBufNotEmpty, .serialPoll, .stbQuery,
    .pollValid, .srqOut, .srqOe, .req, .rsp, .pollByte, .summaryStatusByte,
    .summaryStatusMask
);

// file: tb/sssr_host_model.sv
/* Bus controller model: answers a service request with a serial poll.
   Assumes the service request line is open drain with a pull-up. */
`timescale 1ns/1ps
module sssr_host_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       srqOe,
    input  wire logic       srqArm,
    input  wire logic       pollValid,
    input  wire logic [3:0] pollDly,
    input  wire logic [7:0] pollByte,
    output logic            serialPoll,
    output logic            polled,
    output logic      [7:0] polledByte
);
    logic srqLine;
    assign srqLine = srqOe ? 1'b0 : 1'b1;  // released line floats high
    initial begin
        serialPoll = 1'b0;
        polled     = 1'b0;
        polledByte = 8'h00;
        forever begin
            @(posedge sys_clk);
            if (!rst && srqArm && !srqLine) begin  // interrupt acted on once armed
                repeat (pollDly) @(posedge sys_clk);
                serialPoll <= 1'b1;
                @(posedge sys_clk);
                serialPoll <= 1'b0;
                @(posedge sys_clk);
                polled     <= pollValid;
                polledByte <= pollByte;
                @(posedge sys_clk);
                polled     <= 1'b0;
            end
        end
    end
endmodule

// file: tb/testbench.sv
/* Self-checking bench for the status summary block.
   Assumes the host model polls when armed; one 10 MHz clock. */
`timescale 1ns/1ps
module testbench;
    import sssr_pkg::*;
    logic        rst = 1'b1, powerOn = 1'b0, powerOnClear = 1'b0, outBufNotEmpty = 1'b0;
    logic        opcCmd = 1'b0, busyPrior = 1'b0, scanRunning = 1'b0, stbQuery = 1'b0;
    logic        srqArm = 1'b0, sys_clk, serialPoll, pollValid, srqOut, srqOe, polled;
    logic [3:0]  pollDly = 4'h0;
    logic [63:0] condIn = '0;
    logic [7:0]  pollByte, summaryStatusByte, summaryStatusMask, polledByte;
    sssr_req_t   req = '0;
    sssr_rsp_t   rsp;
    int          n_errors = 0;
    int          n_tests = 0;
    sssr_top #(.GWIDTH(16)) DUT (
        .sys_clk, .rst, .powerOn, .powerOnClear, .condIn, .outBufNotEmpty, .opcCmd,
        .busyPrior, .scanRunning, .req, .serialPoll, .stbQuery, .rsp, .pollByte,
        .pollValid, .summaryStatusByte, .summaryStatusMask, .srqOut, .srqOe);
    sssr_host_model host (.sys_clk, .rst, .srqOe, .srqArm, .pollValid, .pollDly,
        .pollByte, .serialPoll, .polled, .polledByte);
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic bus(input sssr_cmd_t c, input logic [1:0] g, input logic [15:0] d);
        @(posedge sys_clk);
        req <= '{1'b1, c, g, d};
        @(posedge sys_clk);
        req <= '0;
        #1;
    endtask
    task automatic rd(input sssr_cmd_t c, input logic [1:0] g, input logic [15:0] d, exp);
        bus(c, g, d);
        chk("rsp valid", rsp.valid, 1'b1);
        chk("rsp data", rsp.data, exp);
    endtask
    task automatic srq_poll(input logic [3:0] d, input logic [7:0] exp);
        @(posedge sys_clk);
        srqArm  <= 1'b1;
        pollDly <= d;
        for (int i = 0; i < 40 && !polled; i++) tk(1);
        srqArm <= 1'b0;
        chk("poll byte", polledByte, exp);
        chk("srq after poll", srqOe, 1'b0);
    endtask
    task automatic t_events();
        bus(SSSR_CMD_ENA_WR, 2'h0, 16'h0001);
        bus(SSSR_CMD_ENA_WR, 2'h1, 16'h0001);
        @(posedge sys_clk);
        condIn[0]  <= 1'b1;
        condIn[16] <= 1'b1;
        tk(3);
        chk("byte", summaryStatusByte, 16'h000A);
        rd(SSSR_CMD_COND_RD, 2'h0, 16'h0000, 16'h0001);
        @(posedge sys_clk);
        condIn[0] <= 1'b0;
        tk(3);
        rd(SSSR_CMD_COND_RD, 2'h0, 16'h0000, 16'h0000);
        rd(SSSR_CMD_EVT_RD, 2'h0, 16'h0000, 16'h0001);
        chk("byte", summaryStatusByte, 16'h0008);
        @(posedge sys_clk);
        condIn[1] <= 1'b1;
        req       <= '{1'b1, SSSR_CMD_EVT_RD, 2'h0, 16'h0000};
        @(posedge sys_clk);
        req <= '0;
        rd(SSSR_CMD_EVT_RD, 2'h0, 16'h0000, 16'h0002);
        rd(SSSR_CMD_EVT_RD, 2'h0, 16'h0000, 16'h0000);
    endtask
    task automatic t_clear();
        bus(SSSR_CMD_SRE_WR, 2'h0, 16'h0008);
        bus(SSSR_CMD_CLS, 2'h0, 16'h0000);
        chk("byte", summaryStatusByte, 16'h0000);
        chk("mask", summaryStatusMask, 16'h0008);
        rd(SSSR_CMD_ENA_RD, 2'h1, 16'h0000, 16'h0001);
        bus(SSSR_CMD_PRESET, 2'h0, 16'h0000);
        rd(SSSR_CMD_ENA_RD, 2'h1, 16'h0000, 16'h0000);
        bus(SSSR_CMD_SRE_WR, 2'h0, 16'h0000);
        chk("mask", summaryStatusMask, 16'h0000);
        @(posedge sys_clk);
        outBufNotEmpty <= 1'b1;
        #1;
        chk("mav", summaryStatusByte, 16'h0010);
        @(posedge sys_clk);
        outBufNotEmpty <= 1'b0;
        #1;
        chk("mav", summaryStatusByte, 16'h0000);
    endtask
    task automatic t_srq();
        bus(SSSR_CMD_ENA_WR, 2'h0, 16'h0001);
        bus(SSSR_CMD_SRE_WR, 2'h0, 16'h0002);
        @(posedge sys_clk);
        condIn[0] <= 1'b1;
        for (int i = 0; i < 8 && !srqOe; i++) tk(1);
        chk("srq", srqOe, 1'b1);
        @(posedge sys_clk);
        stbQuery <= 1'b1;
        @(posedge sys_clk);
        stbQuery <= 1'b0;
        #1;
        chk("query", rsp.data, 16'h0042);
        tk(2);
        chk("srq", srqOe, 1'b1);
        srq_poll(4'h0, 8'h42);
        chk("byte", summaryStatusByte, 16'h0002);
    endtask
    task automatic t_opc();
        bus(SSSR_CMD_CLS, 2'h0, 16'h0000);
        bus(SSSR_CMD_ENA_WR, 2'h2, 16'h0001);
        bus(SSSR_CMD_SRE_WR, 2'h0, 16'h0020);
        @(posedge sys_clk);
        busyPrior   <= 1'b1;
        scanRunning <= 1'b1;
        opcCmd      <= 1'b1;
        @(posedge sys_clk);
        opcCmd <= 1'b0;
        tk(4);
        chk("opc busy", summaryStatusByte[5], 1'b0);
        @(posedge sys_clk);
        busyPrior <= 1'b0;
        tk(4);
        chk("opc scan", summaryStatusByte[5], 1'b0);
        @(posedge sys_clk);
        scanRunning <= 1'b0;
        tk(3);
        chk("opc done", summaryStatusByte[5], 1'b1);
        srq_poll(4'h5, 8'h60);
    endtask
    task automatic t_power();
        bus(SSSR_CMD_SRE_WR, 2'h0, 16'h0012);
        @(posedge sys_clk);
        powerOn <= 1'b1;
        @(posedge sys_clk);
        powerOn <= 1'b0;
        #1;
        chk("mask kept", summaryStatusMask, 16'h0012);
        rd(SSSR_CMD_ENA_RD, 2'h3, 16'h0001, 16'h0012);
        @(posedge sys_clk);
        powerOnClear <= 1'b1;
        powerOn      <= 1'b1;
        @(posedge sys_clk);
        powerOn <= 1'b0;
        tk(1);
        chk("mask cleared", summaryStatusMask, 16'h0000);
    endtask
    task automatic test_done();
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge sys_clk);
        n_errors++;
        test_done();
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        tk(1);
        chk("reset byte", summaryStatusByte, 16'h0000);
        chk("reset mask", summaryStatusMask, 16'h0000);
        t_events();
        t_clear();
        t_srq();
        t_opc();
        t_power();
        test_done();
    end
endmodule
